/* shared/omc_regs.svh */
// Register map, field positions, reset values and warm-up counts for the
// oscillator mode control block.
// Assumes inclusion by bare name from the shared folder.
`ifndef OMC_REGS_SVH
`define OMC_REGS_SVH

// Oscillator mode register address
`define OMC_OSC_MODE_ADDR     8'h95
// Field positions inside the mode register
`define OMC_BIT_HIGH_OSC_STOP 1
`define OMC_BIT_SLOW_SELECT   2
`define OMC_PM_LO             3
`define OMC_PM_HI             4
// Reset value and writable bits
`define OMC_OSC_MODE_RESET    8'h00
`define OMC_OSC_MODE_WMASK    8'h1E
// Warm-up lengths in high-speed oscillator cycles
`define OMC_WARM_LONG         12'h800
`define OMC_WARM_SHORT        12'h020

`endif

/* shared/omc_pkg.sv */
// Types for the oscillator mode control block.
// Assumes the constants header is available beside it.
package omc_pkg;

   // Fixed high-speed oscillator type option
   typedef enum logic [2:0] {
      OMC_HT_FAST_RC_ONLY = 3'h0,
      OMC_HT_FAST_RC_RTC  = 3'h1,
      OMC_HT_EXT_RC       = 3'h2,
      OMC_HT_XTAL_32K     = 3'h3,
      OMC_HT_XTAL_12M     = 3'h4,
      OMC_HT_XTAL_4M      = 3'h5
   } omc_hosc_type_t;

   // CPU power mode field encoding
   typedef enum logic [1:0] {
      OMC_PM_NORMAL = 2'h0,
      OMC_PM_SLEEP  = 2'h1,
      OMC_PM_GREEN  = 2'h2,
      OMC_PM_RSVD   = 2'h3
   } omc_pm_t;

   // Controller states, one-hot
   typedef enum logic [3:0] {
      OMC_ST_WARM  = 4'h1,
      OMC_ST_RUN   = 4'h2,
      OMC_ST_SLEEP = 4'h4,
      OMC_ST_GREEN = 4'h8
   } omc_state_t;

   // Fixed option straps
   typedef struct packed {
      omc_hosc_type_t hosc_type;   // oscillator type option
      logic [2:0]     high_div;    // normal divider, log2 of 1..128
      logic [1:0]     low_div;     // slow divider, log2 of 1..8
      logic           wdt_enable;  // watchdog enabled
   } omc_opt_t;

   // Whole state of the block
   typedef struct packed {
      omc_state_t  st;
      omc_pm_t     pm;
      logic        slow_sel;
      logic        stop;
      logic [7:0]  rdata;
      logic [2:0]  hsync;
      logic [2:0]  lsync;
      logic        hstab;
      logic        lstab;
      logic [11:0] warm_cnt;
      logic [11:0] warm_lim;
      logic [6:0]  div_cnt;
      logic        cur_slow;
      logic        tick;
      logic        wdt_tick;
   } omc_st_t;

endpackage

/* design/omc_top.sv */
// Oscillator and system-clock control: mode register, oscillator enables,
// warm-up gate, instruction-cycle enable and source switching.
// Assumes oscillator outputs arrive as asynchronous pins and that the
// option straps and wake request come from logic on i_clk.
//
// Contract
// - Stop bit clear keeps the selected high-speed oscillator running.
// - Stop bit set halts high-speed oscillator; slow RC keeps running. Here the high-speed oscillator still runs during warm-up.
// - Stop target follows oscillator type; RTC crystal keeps running.
// - Slow-select bit picks slow RC as system clock, else high-speed.
// - Power-mode field: 00 normal, 01 sleep, 10 green, 11 reserved.
// - Mode register resets to zero; unused bits read zero, ignore writes.
// - Slow RC stops only in power down with watchdog disabled.
// - Slow mode instruction cycle is slow RC divided by 1 to 8.
// - Slow RC also clocks the watchdog.
// - After any reset wait 2048 high-speed cycles before CPU runs.
// - Wake warm-up is 2048 cycles for crystals, 32 for RC types.
// - Normal mode instruction cycle is high clock divided by 1 to 128.
// - RTC option runs system on fast RC, crystal feeds RTC.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "omc_regs.svh"

module omc_top (
   input  wire logic             i_clk,            // 25 MHz system clock
   input  wire logic             i_rst,            // Async reset, high
   input  wire logic [7:0]       i_addr,           // Register address
   input  wire logic [7:0]       i_wdata,          // Write data
   input  wire logic             i_wr,             // Write strobe
   input  wire logic             i_rd,             // Read strobe
   input  wire omc_pkg::omc_opt_t i_opt,           // Fixed option straps
   input  wire logic             i_hosc_pin,       // High-speed osc output
   input  wire logic             i_losc_pin,       // Slow RC output
   input  wire logic             i_wake,           // Wake request pulse
   output logic [7:0]            o_rdata,          // Read data, next cycle
   output logic                  o_int_fast_rc_en, // Fast RC enable
   output logic                  o_ext_osc_en,     // External osc enable
   output logic                  o_rtc_xtal_en,    // RTC crystal enable
   output logic                  o_int_slow_rc_en, // Slow RC enable
   output logic                  o_cpu_tick,       // Instruction cycle pulse
   output logic                  o_wdt_tick,       // Watchdog clock pulse
   output logic                  o_slow_active,    // CPU on slow source
   output logic                  o_warming,        // Warm-up in progress
   output logic                  o_sleep,          // In power down
   output logic                  o_green           // In green mode
);
   import omc_pkg::*;

   omc_st_t s_q;
   omc_st_t s_d;

   // Divider terminal from a log2 divide setting
   function automatic logic [6:0] div_mask(input logic [2:0] lg);
      logic [7:0] m;
      m = (8'h01 << lg) - 8'h01;
      return m[6:0];
   endfunction

   logic       fast_rc_type;
   logic       hosc_run;
   logic       h_edge;
   logic       l_edge;
   logic       new_edge;
   logic       src_edge;
   logic [6:0] mask_cur;
   logic [6:0] mask_new;
   logic       reg_hit;

   // Fast RC types; RTC option also clocks the system from the fast RC
   assign fast_rc_type = (i_opt.hosc_type == OMC_HT_FAST_RC_ONLY) ||
                         (i_opt.hosc_type == OMC_HT_FAST_RC_RTC);
   // High osc runs during warm-up, otherwise unless stopped or sleeping
   assign hosc_run = (s_q.st == OMC_ST_WARM) ||
                     ((s_q.st != OMC_ST_SLEEP) && !s_q.stop);
   // A pin edge counts once the second and third flops agree
   assign h_edge = (s_q.hsync[2] == s_q.hsync[1]) && s_q.hsync[1] && !s_q.hstab;
   assign l_edge = (s_q.lsync[2] == s_q.lsync[1]) && s_q.lsync[1] && !s_q.lstab;
   assign src_edge = s_q.cur_slow ? l_edge : h_edge;
   assign new_edge = s_q.slow_sel ? l_edge : h_edge;
   assign mask_cur = s_q.cur_slow ? div_mask({1'b0, i_opt.low_div})
                                  : div_mask(i_opt.high_div);
   assign mask_new = s_q.slow_sel ? div_mask({1'b0, i_opt.low_div})
                                  : div_mask(i_opt.high_div);
   assign reg_hit = (i_addr == `OMC_OSC_MODE_ADDR);

   // Next-state logic for the whole block
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      s_d.wdt_tick = 1'b0;
      // Three-flop synchronisers for the oscillator pins
      s_d.hsync = {s_q.hsync[1:0], i_hosc_pin};
      s_d.lsync = {s_q.lsync[1:0], i_losc_pin};
      if (s_q.hsync[2] == s_q.hsync[1]) begin
         s_d.hstab = s_q.hsync[1];
      end
      if (s_q.lsync[2] == s_q.lsync[1]) begin
         s_d.lstab = s_q.lsync[1];
      end
      // Watchdog is clocked by slow RC edges while it runs
      s_d.wdt_tick = l_edge && o_int_slow_rc_en;
      // Register read, answered one cycle later; unmapped reads zero
      s_d.rdata = 8'h00;
      if (i_rd && reg_hit) begin
         s_d.rdata = {3'h0, s_q.pm, s_q.slow_sel, s_q.stop, 1'b0};
      end
      // Register write; only bits 4..1 are stored
      if (i_wr && reg_hit) begin
         s_d.stop     = i_wdata[`OMC_BIT_HIGH_OSC_STOP];
         s_d.slow_sel = i_wdata[`OMC_BIT_SLOW_SELECT];
         s_d.pm       = omc_pm_t'(i_wdata[`OMC_PM_HI:`OMC_PM_LO]);
      end
      case (s_q.st)
         OMC_ST_WARM: begin
            // CPU gated until enough high-speed edges are seen
            if (h_edge) begin
               if (s_q.warm_cnt == s_q.warm_lim - 12'h001) begin
                  s_d.st = OMC_ST_RUN;
                  s_d.warm_cnt = 12'h000;
               end else begin
                  s_d.warm_cnt = s_q.warm_cnt + 12'h001;
               end
            end
         end
         OMC_ST_RUN: begin
            // Reserved code 11 is stored but leaves the CPU running
            if (s_q.pm == OMC_PM_SLEEP) begin
               s_d.st = OMC_ST_SLEEP;
            end else if (s_q.pm == OMC_PM_GREEN) begin
               s_d.st = OMC_ST_GREEN;
            end else if (s_q.slow_sel != s_q.cur_slow) begin
               // Switch only on an edge of the new source so the
               // last old cycle is stretched, never shortened
               if (new_edge) begin
                  s_d.cur_slow = s_q.slow_sel;
                  s_d.div_cnt = 7'h00;
                  s_d.tick = (mask_new == 7'h00);
               end
            end else if (src_edge) begin
               if (s_q.div_cnt >= mask_cur) begin
                  s_d.div_cnt = 7'h00;
                  s_d.tick = 1'b1;
               end else begin
                  s_d.div_cnt = s_q.div_cnt + 7'h01;
               end
            end
         end
         OMC_ST_SLEEP: begin
            // Wake: crystals get the long warm-up, RC types the short
            if (i_wake) begin
               s_d.st = OMC_ST_WARM;
               s_d.pm = OMC_PM_NORMAL;
               s_d.cur_slow = 1'b0;
               s_d.slow_sel = 1'b0;
               s_d.warm_cnt = 12'h000;
               s_d.div_cnt = 7'h00;
               s_d.warm_lim = (fast_rc_type || i_opt.hosc_type == OMC_HT_EXT_RC)
                              ? `OMC_WARM_SHORT : `OMC_WARM_LONG;
            end
         end
         OMC_ST_GREEN: begin
            // Oscillators stay as set, so no warm-up on green wake
            if (i_wake) begin
               s_d.st = OMC_ST_RUN;
               s_d.pm = OMC_PM_NORMAL;
            end
         end
         default: begin
            s_d.st = OMC_ST_WARM;
         end
      endcase
   end

   // State register; reset starts the long warm-up
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
         s_q.st <= OMC_ST_WARM;
         s_q.warm_lim <= `OMC_WARM_LONG;
         s_q.pm <= OMC_PM_NORMAL;
      end else begin
         s_q <= s_d;
      end
   end

   // Oscillator enables by type option
   assign o_int_fast_rc_en = fast_rc_type && hosc_run;
   assign o_ext_osc_en     = !fast_rc_type && hosc_run;
   assign o_rtc_xtal_en    = (i_opt.hosc_type == OMC_HT_FAST_RC_RTC) &&
                             (s_q.st != OMC_ST_SLEEP);
   // Slow RC dies only when sleeping with the watchdog off
   assign o_int_slow_rc_en = !((s_q.st == OMC_ST_SLEEP) && !i_opt.wdt_enable);
   assign o_rdata       = s_q.rdata;
   assign o_cpu_tick    = s_q.tick;
   assign o_wdt_tick    = s_q.wdt_tick;
   assign o_slow_active = s_q.cur_slow;
   assign o_warming     = (s_q.st == OMC_ST_WARM);
   assign o_sleep       = (s_q.st == OMC_ST_SLEEP);
   assign o_green       = (s_q.st == OMC_ST_GREEN);

   // Checks on the block's own outputs and internal state
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   AST_RUN_FREE: assert property ((s_q.st == OMC_ST_RUN) && !s_q.stop |->
      (o_int_fast_rc_en || o_ext_osc_en)) else $error("high osc not running");
   AST_STOP_HALT: assert property ((s_q.st == OMC_ST_RUN) && s_q.stop |->
      !o_int_fast_rc_en && !o_ext_osc_en && o_int_slow_rc_en)
      else $error("stop bit did not halt high osc");
   AST_RTC_KEEP: assert property ((i_opt.hosc_type == OMC_HT_FAST_RC_RTC) &&
      !o_sleep |-> o_rtc_xtal_en && !o_ext_osc_en) else $error("rtc crystal stopped");
   AST_SLOW_SEL_WR: assert property (i_wr && reg_hit |=>
      s_q.slow_sel == $past(i_wdata[2])) else $error("slow select not stored");
   AST_SLEEP_ENTER: assert property ((s_q.st == OMC_ST_RUN) &&
      (s_q.pm == OMC_PM_SLEEP) |=> o_sleep) else $error("sleep not entered");
   AST_RDATA_ZERO: assert property (i_rd && reg_hit |=>
      o_rdata[7:5] == 3'h0 && !o_rdata[0]) else $error("unused bits not zero");
   AST_SLOW_RC: assert property (o_int_slow_rc_en == !(o_sleep && !i_opt.wdt_enable))
      else $error("slow rc enable wrong");
   AST_WDT_SRC: assert property (o_wdt_tick |-> $past(o_int_slow_rc_en))
      else $error("watchdog tick without slow rc");
   AST_WARM_GATE: assert property (o_warming ##1 o_warming |-> !o_cpu_tick)
      else $error("cpu clocked during warm-up");
   AST_WAKE_RC: assert property (o_sleep && i_wake && fast_rc_type |=>
      o_warming && s_q.warm_lim == `OMC_WARM_SHORT) else $error("short warm-up not chosen");

   // Only bits 4..1 are stored; wake may clear pm, so check in run only
   AST_WR_MASK: assert property ((s_q.st == OMC_ST_RUN) && i_wr && reg_hit |=>
      {3'h0, s_q.pm, s_q.slow_sel, s_q.stop, 1'b0} ==
      ($past(i_wdata) & `OMC_OSC_MODE_WMASK))
      else $error("mode register write mask wrong");

   // Idle read port must return zero
   AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data not cleared");

   // Crystal types take the long warm-up on wake
   AST_WAKE_XTAL: assert property (o_sleep && i_wake && !fast_rc_type &&
      (i_opt.hosc_type != OMC_HT_EXT_RC) |=> o_warming &&
      s_q.warm_lim == `OMC_WARM_LONG) else $error("long warm-up not chosen");

   // Warm-up counter never passes its terminal count
   AST_WARM_BOUND: assert property (o_warming |-> s_q.warm_cnt < s_q.warm_lim)
      else $error("warm-up counter past limit");

   // RTC option clocks the system from the fast RC during warm-up
   AST_RTC_SYS: assert property ((i_opt.hosc_type == OMC_HT_FAST_RC_RTC) &&
      o_warming |-> o_int_fast_rc_en) else $error("fast rc off in rtc mode");

   // Internal types never enable the external oscillator
   AST_EXT_TYPE: assert property (fast_rc_type |-> !o_ext_osc_en)
      else $error("external osc enabled for internal type");

   // Power down silences every high-speed source and the RTC crystal
   AST_SLEEP_OSC: assert property (o_sleep |->
      !o_int_fast_rc_en && !o_ext_osc_en && !o_rtc_xtal_en)
      else $error("oscillator left running in sleep");

   // Slow RC keeps running outside power down
   AST_SLOW_RC_RUN: assert property (!o_sleep |-> o_int_slow_rc_en)
      else $error("slow rc stopped outside sleep");

   // A pending switch holds the old source and emits no short tick
   AST_SWITCH_HOLD: assert property ((s_q.st == OMC_ST_RUN) &&
      (s_q.slow_sel != s_q.cur_slow) && !new_edge |=>
      (o_slow_active == $past(o_slow_active)) && !o_cpu_tick)
      else $error("source switched off an edge");

   // Instruction ticks only come out of the run state
   AST_TICK_RUN: assert property (o_cpu_tick |-> $past(s_q.st == OMC_ST_RUN))
      else $error("tick outside run");

   // Slow-mode ticks are paced by slow RC edges
   AST_SLOW_TICK: assert property (o_cpu_tick && o_slow_active |-> $past(l_edge))
      else $error("slow tick without slow edge");

   // Watchdog pulses follow slow RC edges
   AST_WDT_EDGE: assert property (o_wdt_tick |-> $past(l_edge))
      else $error("watchdog tick without slow edge");

   // Green holds until a wake and stops the CPU
   AST_GREEN_HOLD: assert property (o_green && !i_wake |=> o_green && !o_cpu_tick)
      else $error("green left without wake");

   // Wake from sleep lands in normal mode on the high-speed clock
   AST_WAKE_CLEAR: assert property (o_sleep && i_wake |=>
      s_q.pm == OMC_PM_NORMAL && !o_slow_active)
      else $error("wake did not clear mode");

   COV_SLEEP_WAKE: cover property (o_sleep ##1 o_warming);
   COV_WARM_DONE: cover property (o_warming ##1 !o_warming);
   COV_RSVD_RUN: cover property ((s_q.pm == OMC_PM_RSVD) && (s_q.st == OMC_ST_RUN));
   COV_GREEN: cover property (o_green ##[1:50] !o_green);
   COV_SLOW_SWITCH: cover property (!o_slow_active ##1 o_slow_active);

endmodule
`default_nettype wire

/* dv/omc_top_tb.sv */
// Self-checking bench for the oscillator mode control block.
// Assumes omc_pkg is compiled first and omc_regs.svh is on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "omc_regs.svh"

module omc_top_tb;
   import omc_pkg::*;

   // One register row: value written, read back, fast RC enable after it
   typedef struct packed {
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic       fast_en;
   } omc_row_t;

   logic       i_clk, i_rst, i_wr, i_rd, i_wake;
   logic       i_hosc_pin = 1'b0;
   logic       i_losc_pin = 1'b0;
   logic [7:0] ph = 8'h00;
   logic [7:0] i_addr, i_wdata, o_rdata, rdv;
   omc_opt_t   i_opt;
   logic       o_int_fast_rc_en, o_ext_osc_en, o_rtc_xtal_en, o_int_slow_rc_en;
   logic       o_cpu_tick, o_wdt_tick, o_slow_active, o_warming, o_sleep, o_green;
   int         errors, checks_done, n, tk, nw;
   omc_row_t   rows [5] = '{'{8'hFF, 8'h1E, 1'b0}, '{8'hE1, 8'h00, 1'b1},
                            '{8'h02, 8'h02, 1'b0}, '{8'h1C, 8'h1C, 1'b1},
                            '{8'h00, 8'h00, 1'b1}};

   omc_top dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_opt, .i_hosc_pin,
                .i_losc_pin, .i_wake, .o_rdata, .o_int_fast_rc_en, .o_ext_osc_en,
                .o_rtc_xtal_en, .o_int_slow_rc_en, .o_cpu_tick, .o_wdt_tick,
                .o_slow_active, .o_warming, .o_sleep, .o_green);

   always #20 i_clk = ~i_clk;

   // Oscillators only run while enabled, so a stop really silences them
   always @(posedge i_clk) begin
      ph         <= ph + 8'h01;
      i_hosc_pin <= ph[1] & (o_int_fast_rc_en | o_ext_osc_en);
      i_losc_pin <= ph[4] & o_int_slow_rc_en;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rng(input int v, input int lo, input int hi);
      chk(16'(v >= lo && v <= hi), 16'h0001);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe, then returns to zero
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
      @(posedge i_clk);
      #1 chk(o_rdata, 8'h00);
   endtask

   task automatic wake;
      @(posedge i_clk);
      i_wake <= 1'b1;
      @(posedge i_clk);
      i_wake <= 1'b0;
   endtask

   // Counts CPU ticks and watchdog ticks over a span of cycles
   task automatic ticks(input int cyc, output int nt, output int nwd);
      nt = 0;
      nwd = 0;
      repeat (cyc) begin
         @(posedge i_clk);
         #1 nt += int'(o_cpu_tick === 1'b1);
         nwd += int'(o_wdt_tick === 1'b1);
      end
   endtask

   // Bounded wait for the warm-up gate to open
   task automatic wait_warm(output int nc, output int nt);
      nc = 0;
      nt = 0;
      while (o_warming === 1'b1 && nc < 9000) begin
         @(posedge i_clk);
         #1 nc++;
         nt += int'(o_cpu_tick === 1'b1);
      end
   endtask

   task automatic rst_dut(input omc_hosc_type_t t, input logic wdt);
      @(posedge i_clk);
      i_rst <= 1'b1;
      i_opt.hosc_type <= t;
      i_opt.wdt_enable <= wdt;
      repeat (16) @(posedge i_clk);
      #1 chk({o_warming, o_cpu_tick, o_int_slow_rc_en}, 3'b101);
      chk({o_int_fast_rc_en, o_ext_osc_en, o_rtc_xtal_en}, {t <= 1, t >= 2, t == 1});
      @(posedge i_clk);
      i_rst <= 1'b0;
      wait_warm(n, tk);
      rng(n, 8180, 8215);
      chk(16'(tk), 16'h0000);
   endtask

   task automatic conclude;
      $display("checks_done=%0d errors=%0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Whole run is near 61k cycles; the limit leaves margin for slow switches
   initial begin
      repeat (95000) @(posedge i_clk);
      errors++;
      $display("[FAIL] %0t ns: run did not finish", $time);
      conclude();
   end

   initial begin
      {i_clk, i_rst, i_wr, i_rd, i_wake} = 5'h00;
      {i_addr, i_wdata, errors, checks_done} = '0;
      i_opt = '{OMC_HT_FAST_RC_ONLY, 3'h1, 2'h1, 1'b0};
      rst_dut(OMC_HT_FAST_RC_ONLY, 1'b0);
      $display("test reset_warmup done");
      // Register rows, reserved codes and unused bits among them
      for (int k = 0; k < 5; k++) begin
         wr(`OMC_OSC_MODE_ADDR, rows[k].wdata);
         rd(`OMC_OSC_MODE_ADDR, rdv);
         chk(rdv, rows[k].rdata);
         chk({o_int_fast_rc_en, o_int_slow_rc_en}, {rows[k].fast_en, 1'b1});
         chk({o_sleep, o_green}, 2'b00);
      end
      wr(8'h94, 8'h1E);
      rd(`OMC_OSC_MODE_ADDR, rdv);
      chk(rdv, 8'h00);
      rd(8'h96, rdv);
      chk(rdv, 8'h00);
      $display("test registers done");
      // Divide by two on each source
      ticks(400, tk, nw);
      rng(tk, 49, 51);
      rng(nw, 12, 13);
      wr(`OMC_OSC_MODE_ADDR, 8'h04);
      ticks(100, tk, nw);
      ticks(640, tk, nw);
      rng(tk, 9, 11);
      chk(o_slow_active, 1'b1);
      wr(`OMC_OSC_MODE_ADDR, 8'h00);
      ticks(60, tk, nw);
      chk(o_slow_active, 1'b0);
      $display("test clock rates done");
      // Green stops the CPU until a wake
      wr(`OMC_OSC_MODE_ADDR, 8'h10);
      ticks(100, tk, nw);
      chk({o_green, o_sleep, tk[7:0]}, 10'h200);
      wake();
      #1 chk(o_green, 1'b0);
      rd(`OMC_OSC_MODE_ADDR, rdv);
      chk(rdv, 8'h00);
      // Power down with watchdog off stops every oscillator
      wr(`OMC_OSC_MODE_ADDR, 8'h08);
      ticks(1, tk, nw);
      chk({o_sleep, o_int_slow_rc_en, o_int_fast_rc_en}, 3'b100);
      wake();
      #1 chk(o_warming, 1'b1);
      wait_warm(n, tk);
      rng(n, 122, 142);
      $display("test modes done");
      // Every oscillator type: stop target, watchdog hold, wake warm-up length
      for (int t = 0; t < 6; t++) begin
         rst_dut(omc_hosc_type_t'(t), t[0]);
         wr(`OMC_OSC_MODE_ADDR, 8'h02);
         #1 chk({o_int_fast_rc_en, o_ext_osc_en, o_rtc_xtal_en}, {2'b00, t == 1});
         wr(`OMC_OSC_MODE_ADDR, 8'h08);
         ticks(1, tk, nw);
         chk(o_int_slow_rc_en, t[0]);
         wake();
         ticks(300, tk, nw);
         chk(o_warming, t >= 3);
      end
      $display("test oscillator types done");
      conclude();
   end

endmodule
`default_nettype wire
